// ### verilog/ubac_pkg.sv
/*
 * ubac_pkg: register map, field positions, reset values and counts for the
 * baud generator, auto-baud, checksum and collision block.
 * assumes: a 32-bit apb slave, one aligned word per register.
 */
package ubac_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL0   = 12'h000;
    localparam logic [11:0] ADDR_CTRL2   = 12'h004;
    localparam logic [11:0] ADDR_DIV_LO  = 12'h008;
    localparam logic [11:0] ADDR_DIV_HI  = 12'h00c;
    localparam logic [11:0] ADDR_TXCHK   = 12'h010;
    localparam logic [11:0] ADDR_RXCHK   = 12'h014;
    localparam logic [11:0] ADDR_FLAGS   = 12'h018;
    localparam logic [11:0] ADDR_CTRL1   = 12'h01c;
    // control zero fields
    localparam int CTRL0_SPEED_BIT  = 7;
    localparam int CTRL0_ABD_BIT    = 6;
    localparam int CTRL0_TX_PATH_ENABLE_BIT   = 5;
    localparam int CTRL0_RX_PATH_ENABLE_BIT   = 4;
    localparam int CTRL0_MODE_LSB   = 0;
    // control two / control one fields
    localparam int CTRL2_CHK_BIT    = 4;
    localparam int CTRL1_WAKE_BIT   = 7;
    // flag register fields (bits 0-2 write one to clear, rx idle read-only, cie read/write)
    localparam int FLAG_COLL_BIT    = 0;
    localparam int FLAG_ABDONE_BIT  = 1;
    localparam int FLAG_ABOVF_BIT   = 2;
    localparam int FLAG_RXIDLE_BIT  = 3;
    localparam int FLAG_CIE_BIT     = 4;
    // mode encodings
    localparam logic [3:0] MODE_ASYNC8 = 4'h0;
    localparam logic [3:0] MODE_ASYNC7 = 4'h1;
    localparam logic [3:0] MODE_LIN    = 4'hc;
    localparam logic [3:0] MODE_DALI   = 4'h8;
    // reset values
    localparam logic [7:0]  CTRL0_RESET = 8'h00;
    localparam logic [15:0] DIV_RESET   = 16'h0000;
    // auto-baud: falling edges of the sync character
    localparam logic [2:0]  ABD_EDGES   = 3'h5;
    // prescale ratios: base clock is fosc/4 or fosc/16, abd clock one eighth
    localparam logic [6:0]  PRE_FAST    = 7'h03;
    localparam logic [6:0]  PRE_SLOW    = 7'h0f;
    localparam logic [6:0]  PRE_ABD_F   = 7'h1f;
    localparam logic [6:0]  PRE_ABD_S   = 7'h7f;

    typedef enum logic [2:0] {
        ABD_IDLE = 3'b001,
        ABD_WAIT = 3'b010,
        ABD_MEAS = 3'b100
    } ubac_abd_type;
endpackage

// ### verilog/ubac_baud_timer.sv
/*
 * ubac_baud_timer: free-running 16-bit baud timer with prescaler.
 * assumes: divisor and speed come from registers in the same clock domain.
 */
`timescale 1ns/10ps
module ubac_baud_timer
    import ubac_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        restart,
    input  wire logic        speed_fast,
    input  wire logic [15:0] divisor,
    output logic             base_tick,
    output logic             baud_tick
);
    logic [6:0]  pre_reg;
    logic [15:0] cnt_reg;
    wire  [6:0]  pre_top  = speed_fast ? PRE_FAST : PRE_SLOW;
    wire         pre_wrap = (pre_reg == pre_top);
    wire         cnt_wrap = pre_wrap && (cnt_reg == divisor);

    // base tick every 4 or 16 clocks, baud every (n+1) base ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 7'h00;
            cnt_reg <= 16'h0000;
        end else if (restart) begin
            pre_reg <= 7'h00;
            cnt_reg <= 16'h0000;
        end else begin
            pre_reg <= pre_wrap ? 7'h00 : pre_reg + 7'h01;
            if (pre_wrap)
                cnt_reg <= cnt_wrap ? 16'h0000 : cnt_reg + 16'h0001;
        end
    end

    assign base_tick = pre_wrap;
    assign baud_tick = cnt_wrap;
endmodule

// ### verilog/ubac_core.sv
/*
 * ubac_core: apb register file, baud timer, auto-baud measurement,
 * checksum adders and transmit collision detection.
 * assumes: rx_line is synchronous to pclk; framer pulses tx_byte_done and
 * rx_byte_done with the byte, and dali_midbit_miss from its decoder.
 */
`timescale 1ns/10ps
module ubac_core
    import ubac_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_line,
    input  wire logic        tx_line,
    input  wire logic        tx_byte_done,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        rx_byte_done,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        dali_midbit_miss,
    output logic             baud_tick,
    output logic             rx_hold_idle,
    output logic             rx_idle_status,
    output logic             collision_irq,
    output logic             rx_activity,
    output logic             tx_activity
);
    // registers
    logic [7:0]   ctrl0_reg;
    logic         checksum_adder_enable_reg;
    logic         wake_on_break_enable_reg;
    logic [15:0]  div_reg;
    logic [7:0]   tx_checksum_reg;
    logic [7:0]   rx_checksum_reg;
    logic         collision_flag_reg;
    logic         autobaud_done_flag_reg;
    logic         autobaud_overflow_flag_reg;
    logic         collision_irq_enable_reg;
    logic         rx_idle_reg;
    logic [31:0]  prdata_reg;
    logic         pready_reg;
    logic         pslverr_reg;
    logic         rx_prev_reg;
    logic         tx_prev_reg;
    logic         rx_act_reg;
    logic         tx_act_reg;
    logic         baud_reg;
    logic         coll_irq_reg;
    logic [7:0]   last_tx_reg;
    logic         echo_pend_reg;
    ubac_abd_type abd_state_reg;
    logic [2:0]   fall_cnt_reg;
    logic [2:0]   rise_cnt_reg;
    logic [6:0]   abd_pre_reg;
    logic [16:0]  abd_cnt_reg;
    logic         break_seen_reg;
    logic         hold_idle_reg;
    logic         baud_tick_w;

    // 8-bit add with carry folded back in
    function automatic logic [7:0] add_fold(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

    // bus decode: single-cycle access, answered in the access phase
    wire acc      = psel && penable && !pready_reg;
    wire wr       = acc && pwrite;
    wire hit      = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
    wire wr_ctrl0 = wr && paddr == ADDR_CTRL0;
    wire wr_ctrl2 = wr && paddr == ADDR_CTRL2;
    wire wr_divlo = wr && paddr == ADDR_DIV_LO;
    wire wr_divhi = wr && paddr == ADDR_DIV_HI;
    wire wr_txchk = wr && paddr == ADDR_TXCHK;
    wire wr_rxchk = wr && paddr == ADDR_RXCHK;
    wire wr_flags = wr && paddr == ADDR_FLAGS;
    wire wr_ctrl1 = wr && paddr == ADDR_CTRL1;

    // mode decode
    wire [3:0] mode   = ctrl0_reg[CTRL0_MODE_LSB +: 4];
    wire is_lin       = (mode == MODE_LIN);
    wire is_dali      = (mode == MODE_DALI);
    wire is_async8    = (mode == MODE_ASYNC8);
    wire speed_fast   = ctrl0_reg[CTRL0_SPEED_BIT];
    wire tx_en        = ctrl0_reg[CTRL0_TX_PATH_ENABLE_BIT];
    wire rx_en        = ctrl0_reg[CTRL0_RX_PATH_ENABLE_BIT];
    wire abd_armed    = ctrl0_reg[CTRL0_ABD_BIT] && is_async8 && !is_dali;
    wire chk_run      = checksum_adder_enable_reg && !is_lin;

    // line edges
    wire rx_fall = rx_prev_reg && !rx_line;
    wire rx_rise = !rx_prev_reg && rx_line;

    // auto-baud timing at one eighth of the base clock
    wire [6:0] abd_top  = speed_fast ? PRE_ABD_F : PRE_ABD_S;
    wire       abd_tick = (abd_pre_reg == abd_top);
    wire       abd_meas = (abd_state_reg == ABD_MEAS);
    wire       abd_last = abd_meas && rx_fall && (fall_cnt_reg == ABD_EDGES - 3'h1);
    wire       abd_ok   = abd_last && !abd_cnt_reg[16] && !autobaud_overflow_flag_reg;
    // average bit period: eight bits counted at one eighth rate, minus one
    wire [15:0] abd_div = abd_cnt_reg[15:0] - 16'h0001;

    // abd start: after a break when wake is armed, else on first fall
    wire abd_start = (abd_state_reg == ABD_WAIT) && rx_fall
                     && (!wake_on_break_enable_reg || break_seen_reg);

    // collision: echoed word must match the last transmitted word
    wire coll_chk  = rx_en && tx_en;
    wire coll_hit  = coll_chk && ((rx_byte_done && echo_pend_reg && rx_byte != last_tx_reg)
                     || (is_dali && tx_en && dali_midbit_miss));

    ubac_baud_timer u_timer (
        .pclk       (pclk),
        .presetn    (presetn),
        .restart    (wr_divlo || wr_divhi || abd_ok),
        .speed_fast (speed_fast),
        .divisor    (div_reg),
        .base_tick  (),
        .baud_tick  (baud_tick_w)
    );

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg                 <= CTRL0_RESET;
            checksum_adder_enable_reg <= 1'b0;
            wake_on_break_enable_reg  <= 1'b0;
        end else begin
            if (wr_ctrl0)
                ctrl0_reg <= pwdata[7:0];
            else if (abd_last)
                ctrl0_reg[CTRL0_ABD_BIT] <= 1'b0;
            if (wr_ctrl2)
                checksum_adder_enable_reg <= pwdata[CTRL2_CHK_BIT];
            if (wr_ctrl1)
                wake_on_break_enable_reg <= pwdata[CTRL1_WAKE_BIT];
            else if (abd_start)
                wake_on_break_enable_reg <= 1'b0;
        end
    end

    // divisor: software write, or measured value on success only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_reg <= DIV_RESET;
        else if (abd_ok)
            div_reg <= abd_div;
        else if (wr_divlo)
            div_reg[7:0] <= pwdata[7:0];
        else if (wr_divhi)
            div_reg[15:8] <= pwdata[7:0];
    end

    // checksum adders; a byte arriving with a software write wins the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_checksum_reg <= 8'h00;
            rx_checksum_reg <= 8'h00;
        end else begin
            if (chk_run && tx_byte_done)
                tx_checksum_reg <= add_fold(tx_checksum_reg, tx_byte);
            else if (wr_txchk)
                tx_checksum_reg <= pwdata[7:0];
            if (chk_run && rx_byte_done)
                rx_checksum_reg <= add_fold(rx_checksum_reg, rx_byte);
            else if (wr_rxchk)
                rx_checksum_reg <= pwdata[7:0];
        end
    end

    // status flags: hardware set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            collision_flag_reg         <= 1'b0;
            autobaud_done_flag_reg     <= 1'b0;
            autobaud_overflow_flag_reg <= 1'b0;
            collision_irq_enable_reg   <= 1'b0;
        end else begin
            collision_flag_reg <= coll_hit
                || (collision_flag_reg && !(wr_flags && pwdata[FLAG_COLL_BIT]));
            autobaud_done_flag_reg <= abd_last
                || (autobaud_done_flag_reg && !(wr_flags && pwdata[FLAG_ABDONE_BIT]));
            autobaud_overflow_flag_reg <= (abd_meas && abd_cnt_reg[16])
                || (autobaud_overflow_flag_reg && !(wr_flags && pwdata[FLAG_ABOVF_BIT]));
            if (wr_flags)
                collision_irq_enable_reg <= pwdata[FLAG_CIE_BIT];
        end
    end

    // remember the last sent word until its echo comes back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_tx_reg   <= 8'h00;
            echo_pend_reg <= 1'b0;
        end else if (tx_byte_done) begin
            last_tx_reg   <= tx_byte;
            echo_pend_reg <= 1'b1;
        end else if (rx_byte_done) begin
            echo_pend_reg <= 1'b0;
        end
    end

    // auto-baud state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abd_state_reg <= ABD_IDLE;
            fall_cnt_reg  <= 3'h0;
        end else begin
            case (abd_state_reg)
                ABD_IDLE: begin
                    if (abd_armed)
                        abd_state_reg <= ABD_WAIT;
                end
                ABD_WAIT: begin
                    if (!abd_armed)
                        abd_state_reg <= ABD_IDLE;
                    else if (abd_start) begin
                        abd_state_reg <= ABD_MEAS;
                        fall_cnt_reg  <= 3'h1;
                    end
                end
                ABD_MEAS: begin
                    if (!ctrl0_reg[CTRL0_ABD_BIT] || abd_last)
                        abd_state_reg <= ABD_IDLE;
                    else if (rx_fall)
                        fall_cnt_reg <= fall_cnt_reg + 3'h1;
                end
                default: abd_state_reg <= ABD_IDLE;
            endcase
        end
    end

    // measurement counter; bit 16 marks overflow and sticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abd_pre_reg <= 7'h00;
            abd_cnt_reg <= 17'h00000;
        end else if (abd_start) begin
            // the fall is seen one clock late, so that clock already counts
            abd_pre_reg <= 7'h01;
            abd_cnt_reg <= 17'h00000;
        end else if (abd_meas) begin
            abd_pre_reg <= abd_tick ? 7'h00 : abd_pre_reg + 7'h01;
            if (abd_tick && !abd_cnt_reg[16])
                abd_cnt_reg <= abd_cnt_reg + 17'h00001;
        end
    end

    // break detect for wake: low line then return high while waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            break_seen_reg <= 1'b0;
        else if (abd_state_reg != ABD_WAIT || !wake_on_break_enable_reg)
            break_seen_reg <= 1'b0;
        else if (rx_rise)
            break_seen_reg <= 1'b1;
    end

    // rx idle: low from first fall to fifth rise of the sync character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_idle_reg  <= 1'b1;
            rise_cnt_reg <= 3'h0;
        end else if (abd_start) begin
            rx_idle_reg  <= 1'b0;
            rise_cnt_reg <= 3'h0;
        end else if (!rx_idle_reg && rx_rise) begin
            rise_cnt_reg <= rise_cnt_reg + 3'h1;
            if (rise_cnt_reg == ABD_EDGES - 3'h1)
                rx_idle_reg <= 1'b1;
        end
    end

    // line activity pulses for the external limit timer, and other outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_reg  <= 1'b1;
            tx_prev_reg  <= 1'b1;
            rx_act_reg   <= 1'b0;
            tx_act_reg   <= 1'b0;
            baud_reg     <= 1'b0;
            coll_irq_reg <= 1'b0;
        end else begin
            rx_prev_reg  <= rx_line;
            tx_prev_reg  <= tx_line;
            rx_act_reg   <= rx_line ^ rx_prev_reg;
            tx_act_reg   <= tx_line ^ tx_prev_reg;
            baud_reg     <= baud_tick_w && (abd_state_reg != ABD_MEAS);
            coll_irq_reg <= collision_flag_reg && collision_irq_enable_reg;
        end
    end

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (paddr)
            ADDR_CTRL0:  rd_mux = {24'h000000, ctrl0_reg};
            ADDR_CTRL2:  rd_mux = {27'h0000000, checksum_adder_enable_reg, 4'h0};
            ADDR_DIV_LO: rd_mux = {24'h000000, div_reg[7:0]};
            ADDR_DIV_HI: rd_mux = {24'h000000, div_reg[15:8]};
            ADDR_TXCHK:  rd_mux = {24'h000000, tx_checksum_reg};
            ADDR_RXCHK:  rd_mux = {24'h000000, rx_checksum_reg};
            ADDR_FLAGS:  rd_mux = {27'h0000000, collision_irq_enable_reg, rx_idle_reg,
                                   autobaud_overflow_flag_reg, autobaud_done_flag_reg,
                                   collision_flag_reg};
            ADDR_CTRL1:  rd_mux = {24'h000000, wake_on_break_enable_reg, 7'h00};
            default:     rd_mux = 32'h00000000;
        endcase
    end

    // apb answer: ready one cycle into the access phase, error if unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else begin
            pready_reg  <= acc;
            pslverr_reg <= acc && !hit;
            if (acc && !pwrite)
                prdata_reg <= rd_mux;
        end
    end

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign baud_tick      = baud_reg;
    assign rx_hold_idle   = hold_idle_reg;
    assign rx_idle_status = rx_idle_reg;
    assign collision_irq  = coll_irq_reg;
    assign rx_activity    = rx_act_reg;
    assign tx_activity    = tx_act_reg;

    // receiver held idle while measuring (registered)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hold_idle_reg <= 1'b0;
        else
            hold_idle_reg <= abd_meas || abd_start;
    end
endmodule

// ### bench/ubac_core_assertions.sv
/* ubac_core_assertions: port timing checks for ubac_core.
   assumes: bound to ubac_core, single pclk domain, synchronous line inputs. */
`timescale 1ns/10ps
module ubac_core_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic rx_byte_done,
    input wire logic dali_midbit_miss,
    input wire logic baud_tick,
    input wire logic rx_hold_idle,
    input wire logic rx_idle_status,
    input wire logic collision_irq,
    input wire logic rx_activity,
    input wire logic tx_activity
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // anything that may legally raise the collision interrupt
    wire coll_cause = rx_byte_done | dali_midbit_miss | (psel & penable & pwrite);

    a_rx_edge_seen: assert property ($changed(rx_line) |=> rx_activity)
        else $error("rx edge gave no activity pulse");
    a_rx_quiet_line: assert property (!$changed(rx_line) |=> !rx_activity)
        else $error("rx activity without an rx edge");
    a_tx_edge_seen: assert property ($changed(tx_line) |=> tx_activity)
        else $error("tx edge gave no activity pulse");
    a_tick_single: assert property (baud_tick |=> !baud_tick)
        else $error("baud tick longer than one cycle");
    a_hold_starts_low: assert property ($rose(rx_hold_idle) |-> !rx_line)
        else $error("measurement began away from a falling edge");
    a_hold_means_busy: assert property (rx_hold_idle |-> !rx_idle_status)
        else $error("idle status high while measuring");
    a_idle_back_high: assert property ($rose(rx_idle_status) |-> rx_line)
        else $error("idle status rose while line low");
    a_idle_drop_low: assert property ($fell(rx_idle_status) |-> !rx_line)
        else $error("idle status fell while line high");
    a_no_tick_measuring: assert property (rx_hold_idle [*2] |-> !baud_tick)
        else $error("baud tick while measuring");
    a_irq_has_cause: assert property ($rose(collision_irq)
        |-> $past(coll_cause) || $past(coll_cause, 2))
        else $error("collision irq rose without cause");
    a_answer_next: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("slave error without ready");
endmodule

bind ubac_core ubac_core_assertions u_ubac_core_assertions (.pclk, .presetn, .psel,
    .penable, .pwrite, .pready, .pslverr, .rx_line, .tx_line, .rx_byte_done,
    .dali_midbit_miss, .baud_tick, .rx_hold_idle, .rx_idle_status, .collision_irq,
    .rx_activity, .tx_activity);

// ### bench/ubac_remote_node.sv
/* ubac_remote_node: far serial node driving the receive line plus the byte strobe.
   assumes: line idles high; bit length given in pclk cycles. */
`timescale 1ns/10ps
module ubac_remote_node (
    input  wire logic pclk,
    output logic      rx_line,
    output logic      rx_byte_done,
    output logic [7:0] rx_byte
);
    // idle line high, no strobe
    initial begin
        rx_line      = 1'b1;
        rx_byte_done = 1'b0;
        rx_byte      = 8'h00;
    end

    // start bit, eight data bits lsb first, stop bit, then a one-cycle byte strobe
    task automatic send_frame(input logic [7:0] data, input int bit_cycles);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            rx_line <= frame[i];
            repeat (bit_cycles - 1) @(posedge pclk);
        end
        rx_byte      <= data;
        rx_byte_done <= 1'b1;
        @(posedge pclk);
        rx_byte_done <= 1'b0;
        rx_byte      <= ~data; // stale byte must not be reused
    endtask
endmodule

// ### bench/uart_baud_autobaud_checksum_tb_top.sv
/* tb top: apb master, framer strobes and remote node around ubac_core.
   assumes: ubac_pkg map, 50 MHz pclk, registered one-cycle apb answer. */
`timescale 1ns/10ps
module uart_baud_autobaud_checksum_tb_top import ubac_pkg::*;;
    localparam int BIT = 40; // sync bit length in pclk cycles
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        rx_line, tx_line, tx_byte_done, rx_byte_done, dali_midbit_miss;
    logic [7:0]  tx_byte, rx_byte;
    logic        baud_tick, rx_hold_idle, rx_idle_status, collision_irq;
    logic        rx_activity, tx_activity;
    int          errors, comparisons, cycles;

    ubac_core u_ubac_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_line, .tx_line, .tx_byte_done, .tx_byte,
        .rx_byte_done, .rx_byte, .dali_midbit_miss, .baud_tick, .rx_hold_idle,
        .rx_idle_status, .collision_irq, .rx_activity, .tx_activity);
    ubac_remote_node u_ubac_remote_node (.pclk, .rx_line, .rx_byte_done, .rx_byte);

    // 20 ns period
    always #10 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one apb transfer; an edge passes first so back-to-back calls never collide
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the wait ends on pready; only the hang guard stops one that never ends
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // framer strobe for one sent byte; line dips so tx activity moves
    task automatic send_tx(input logic [7:0] b, input logic miss);
        @(posedge pclk);
        tx_line          <= 1'b0;
        dali_midbit_miss <= miss;
        @(posedge pclk);
        dali_midbit_miss <= 1'b0;
        tx_byte_done     <= 1'b1;
        tx_byte          <= b;
        @(posedge pclk);
        tx_byte_done <= 1'b0;
        tx_byte      <= ~b;
        tx_line      <= 1'b1;
    endtask

    task automatic regs_case;
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check(rd, 32'h1 << FLAG_RXIDLE_BIT);
        apb(1'b1, ADDR_TXCHK, 32'h5a);
        apb(1'b0, ADDR_TXCHK, 32'h0);
        check(rd, 32'h5a);
        apb(1'b1, 12'h020, 32'hff);
        apb(1'b0, 12'h020, 32'h0);
        check({rd[30:0], err}, 32'h1);
    endtask

    // payload plus inverted sum; f0+20 exercises the folded carry; lin never adds
    task automatic sum_case(input logic en, input logic [3:0] mode);
        logic run;
        run = en && (mode != MODE_LIN);
        apb(1'b1, ADDR_CTRL0, {28'h0, mode});
        apb(1'b1, ADDR_CTRL2, 32'(en) << CTRL2_CHK_BIT);
        apb(1'b1, ADDR_TXCHK, 32'h0);
        apb(1'b1, ADDR_RXCHK, 32'h0);
        send_tx(8'hf0, 1'b0);
        send_tx(8'h20, 1'b0);
        send_tx(8'hee, 1'b0);
        u_ubac_remote_node.send_frame(8'hf0, 4);
        u_ubac_remote_node.send_frame(8'h20, 4);
        u_ubac_remote_node.send_frame(8'hee, 4);
        apb(1'b0, ADDR_TXCHK, 32'h0);
        check(rd, run ? 32'hff : 32'h0);
        apb(1'b0, ADDR_RXCHK, 32'h0);
        check(8'(rd[7:0] + 8'h1), run ? 32'h0 : 32'h1);
    endtask

    task automatic coll_case(input logic [7:0] ctrl, input logic cie, input logic [7:0] echo,
                             input logic miss, input logic exp);
        apb(1'b1, ADDR_CTRL0, {24'h0, ctrl});
        apb(1'b1, ADDR_FLAGS, 32'h7 | (32'(cie) << FLAG_CIE_BIT));
        send_tx(8'ha5, miss);
        u_ubac_remote_node.send_frame(echo, 4);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check(rd[FLAG_COLL_BIT], exp);
        check(collision_irq, exp & cie);
    endtask

    task automatic baud_case(input logic fast, input logic [7:0] div);
        int n;
        int p;
        p = (fast ? 4 : 16) * (div + 1);
        apb(1'b1, ADDR_CTRL0, 32'(fast) << CTRL0_SPEED_BIT);
        apb(1'b1, ADDR_DIV_HI, 32'h1);
        apb(1'b1, ADDR_DIV_HI, 32'h0);
        apb(1'b1, ADDR_DIV_LO, {24'h0, div});
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (baud_tick !== 1'b1 && n < 5000);
            if (k == 0) check(n <= p + 2, 1'b1);
        end
        check(n, p);
    endtask

    // sync character at BIT cycles per bit with the fast base clock
    task automatic abd_case(input logic [3:0] mode, input logic [15:0] exp);
        apb(1'b1, ADDR_DIV_LO, 32'h3);
        apb(1'b1, ADDR_CTRL0, {24'h0, 4'hc, mode});
        u_ubac_remote_node.send_frame(8'h55, BIT);
        apb(1'b0, ADDR_DIV_LO, 32'h0);
        check(rd, exp);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        check(rd[FLAG_ABDONE_BIT], mode == MODE_ASYNC8);
        check(rx_idle_status, 1'b1);
        apb(1'b1, ADDR_FLAGS, 32'h1 << FLAG_ABDONE_BIT);
        apb(1'b1, ADDR_CTRL0, 32'h0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_line = 1'b1;
        tx_byte_done = 1'b0;
        tx_byte = 8'h00;
        dali_midbit_miss = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        regs_case();
        sum_case(1'b1, MODE_ASYNC8);
        sum_case(1'b0, MODE_ASYNC8);
        sum_case(1'b1, MODE_LIN);
        coll_case(8'h30, 1'b1, 8'ha5, 1'b0, 1'b0);
        coll_case(8'h30, 1'b1, 8'ha4, 1'b0, 1'b1);
        coll_case(8'h30, 1'b0, 8'ha4, 1'b0, 1'b1);
        coll_case(8'h20, 1'b1, 8'ha4, 1'b0, 1'b0);
        coll_case({4'h3, MODE_DALI}, 1'b1, 8'ha5, 1'b1, 1'b1);
        baud_case(1'b1, 8'h02);
        baud_case(1'b0, 8'h02);
        baud_case(1'b1, 8'h00);
        abd_case(MODE_ASYNC8, BIT * 8 / 32 - 1);
        abd_case(MODE_DALI, 16'h3);
        abd_case(MODE_ASYNC7, 16'h3);
        end_of_test();
    end

    // hang guard, well above the roughly 2.2k cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 50000) begin
            errors++;
            end_of_test();
        end
    end
endmodule
